// file: rtl/ebi_defs.vh
// Purpose: Constants for the external bus interface
// Assumes: 32-bit register port, word aligned offsets
// Notes: Bank regions are fixed 32 MB windows picked by address bits 27:25
`ifndef EBI_DEFS_VH
`define EBI_DEFS_VH

// Register offsets
`define EBI_BANK_CFG_BASE 8'h00
`define EBI_STATUS 8'h20

// Bank configuration fields
`define EBI_CFG_CYC_LSB 0
`define EBI_CFG_CYC_MSB 3
`define EBI_CFG_SIZE_LSB 4
`define EBI_CFG_SIZE_MSB 6
`define EBI_CFG_WID_LSB 8
`define EBI_CFG_WID_MSB 9
`define EBI_CFG_RESET 10'h00F

// Status fields
`define EBI_ST_WID_LSB 0
`define EBI_ST_WID_MSB 1
`define EBI_ST_TEST 2
`define EBI_ST_BUSY 3
`define EBI_ST_HOLD 4
`define EBI_ST_STRAP_RESET 2'h0

// Width codes
`define EBI_WID_8 2'h0
`define EBI_WID_16 2'h1
`define EBI_WID_32 2'h2
`define EBI_WID_TEST 2'h3

// Bank address slicing
`define EBI_BANK_LSB 25
`define EBI_BANK_MSB 27

`endif

// file: rtl/bank_decode.v
// Purpose: Maps a system address onto one bank chip select
// Assumes: Eight fixed 32 MB windows, each trimmed by a size code
// Notes: Size code n keeps the low (32 MB >> n) of the window
`timescale 1ns/1ps
`include "ebi_defs.vh"
module bank_decode #(
    parameter BANKS = 8
) (
    input wire [27:0] addr_i,
    input wire [3*BANKS-1:0] size_i,
    output reg [BANKS-1:0] sel_o,
    output reg hit_o
);
    integer i;
    reg [2:0] bank;
    reg [2:0] code;
    reg [24:0] limit;

    // One-hot select, clear when the offset overruns the region
    always @* begin
        bank = addr_i[`EBI_BANK_MSB:`EBI_BANK_LSB];
        code = 3'h0;
        for (i = 0; i < BANKS; i = i + 1) begin
            if (bank == i[2:0]) begin
                code = size_i[3*i +: 3];
            end
        end
        limit = 25'h1FFFFFF >> code;
        hit_o = (addr_i[24:0] <= limit);
        sel_o = {BANKS{1'b0}};
        for (i = 0; i < BANKS; i = i + 1) begin
            if (hit_o && bank == i[2:0]) begin
                sel_o[i] = 1'b1;
            end
        end
    end
endmodule // bank_decode

// file: rtl/lane_pack.v
// Purpose: Steers data and byte lanes for 8, 16 and 32-bit banks
// Assumes: One beat per access, no wider than the bank port
// Notes: Narrow ports use the low lanes of the data bus
`timescale 1ns/1ps
`include "ebi_defs.vh"
module lane_pack (
    input wire [1:0] width_i,
    input wire [1:0] addr_lo_i,
    input wire [31:0] wdata_i,
    input wire [3:0] be_i,
    input wire [31:0] pin_data_i,
    output reg [31:0] pin_data_o,
    output reg [3:0] lanes_o,
    output reg [31:0] rdata_o
);
    // Shift the addressed byte or halfword down to lane 0
    always @* begin
        case (width_i)
            `EBI_WID_8: begin
                pin_data_o = wdata_i >> {addr_lo_i, 3'h0};
                lanes_o = {3'h0, |(be_i & (4'h1 << addr_lo_i))};
                rdata_o = {24'h000000, pin_data_i[7:0]} << {addr_lo_i, 3'h0};
            end
            `EBI_WID_16: begin
                pin_data_o = addr_lo_i[1] ? {16'h0000, wdata_i[31:16]} : wdata_i;
                lanes_o = addr_lo_i[1] ? {2'h0, be_i[3:2]} : {2'h0, be_i[1:0]};
                rdata_o = addr_lo_i[1] ? {pin_data_i[15:0], 16'h0000} : {16'h0000, pin_data_i[15:0]};
            end
            default: begin
                pin_data_o = wdata_i;
                lanes_o = be_i;
                rdata_o = pin_data_i;
            end
        endcase
    end
endmodule // lane_pack

// file: rtl/external_bus_interface.v
// Purpose: External memory bus controller with bank decode and bus hold
// Assumes: Pins synchronous to clock_i; board straps steady through reset
// Notes: One request at a time; register port has no wait states
// Behaviour
// - Strap pins set bank 0 width, 11 test
// - Strap level caught while reset is high
// - Address outputs carry offset within bank
// - Data bus sampled on reads, driven on writes
// - Chip select active when address hits bank
// - Software sets access cycles and bank size
// - Write strobe low marks write cycle
// - Read strobe low marks read cycle
// - Four low byte lane enables, write/SRAM
// - Acknowledge only after bus released
// - Wait input low holds current cycle
`timescale 1ns/1ps
`include "ebi_defs.vh"
module external_bus_interface #(
    parameter BANKS = 8
) (
    input wire clock_i,
    input wire srst_i,
    input wire [1:0] boot_width_select_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output wire [31:0] reg_rdata_o,
    // Internal access request
    input wire req_valid_i,
    input wire req_write_i,
    input wire [27:0] req_addr_i,
    input wire [31:0] req_wdata_i,
    input wire [3:0] req_be_i,
    output wire req_ready_o,
    output wire req_done_o,
    output wire req_error_o,
    output wire [31:0] req_rdata_o,
    // Memory pins
    output wire [24:0] addr_o,
    input wire [31:0] data_i,
    output wire [31:0] data_o,
    output wire data_oe_n_o,
    output wire [BANKS-1:0] bank_select_n_o,
    output wire write_strobe_n_o,
    output wire read_strobe_n_o,
    output wire [3:0] write_byte_lane_n_o,
    output wire [3:0] sram_byte_lane_n_o,
    output wire ctrl_oe_n_o,
    input wire cycle_extend_n_i,
    input wire bus_hold_request_n_i,
    output wire bus_hold_ack_n_o,
    output wire test_mode_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ACCESS = 4'h2;
    localparam [3:0] ST_RELEASE = 4'h4;
    localparam [3:0] ST_HOLD = 4'h8;

    reg [3:0] state_q, state_d;
    reg [1:0] strap_q;
    reg [9:0] cfg_q [0:BANKS-1];
    reg [31:0] reg_rdata_q;
    reg [3:0] cnt_q, cnt_d;
    reg [24:0] addr_q, addr_d;
    reg [31:0] data_q, data_d;
    reg [BANKS-1:0] sel_q, sel_d;
    reg [3:0] lanes_q, lanes_d;
    reg write_q, write_d;
    reg [1:0] width_q, width_d;
    reg [1:0] lo_q, lo_d;
    reg [31:0] rdata_q;
    reg done_q, done_d;
    reg error_q, error_d;
    reg ack_q, ack_d;

    wire [3*BANKS-1:0] size_flat;
    wire [BANKS-1:0] dec_sel;
    wire dec_hit;
    wire [31:0] pack_data;
    wire [3:0] pack_lanes;
    wire [31:0] unpack_rdata;
    wire [2:0] req_bank;
    wire [1:0] req_width;
    wire [1:0] boot_width;
    wire [3:0] req_cycles;
    wire idle;
    wire hold_wanted;
    integer i;

    // Flatten size codes for the decoder
    genvar g;
    generate
        for (g = 0; g < BANKS; g = g + 1) begin : g_size
            assign size_flat[3*g +: 3] = cfg_q[g][`EBI_CFG_SIZE_MSB:`EBI_CFG_SIZE_LSB];
        end
    endgenerate

    bank_decode #(
        .BANKS(BANKS)
    ) u_decode (
        .addr_i(req_addr_i),
        .size_i(size_flat),
        .sel_o(dec_sel),
        .hit_o(dec_hit)
    );

    // Write path steering uses the incoming request
    lane_pack u_wpack (
        .width_i(req_width),
        .addr_lo_i(req_addr_i[1:0]),
        .wdata_i(req_wdata_i),
        .be_i(req_be_i),
        .pin_data_i(32'h00000000),
        .pin_data_o(pack_data),
        .lanes_o(pack_lanes),
        .rdata_o()
    );

    // Read path steering uses the latched access
    lane_pack u_rpack (
        .width_i(width_q),
        .addr_lo_i(lo_q),
        .wdata_i(32'h00000000),
        .be_i(4'h0),
        .pin_data_i(data_i),
        .pin_data_o(),
        .lanes_o(),
        .rdata_o(unpack_rdata)
    );

    // Strap decode; test pattern runs bank 0 as 32-bit
    assign boot_width = (strap_q == `EBI_WID_TEST) ? `EBI_WID_32 : strap_q;
    assign test_mode_o = (strap_q == `EBI_WID_TEST);
    assign req_bank = req_addr_i[`EBI_BANK_MSB:`EBI_BANK_LSB];
    assign req_width = (req_bank == 3'h0) ? boot_width :
        cfg_q[req_bank][`EBI_CFG_WID_MSB:`EBI_CFG_WID_LSB];
    assign req_cycles = cfg_q[req_bank][`EBI_CFG_CYC_MSB:`EBI_CFG_CYC_LSB];

    assign idle = state_q[0];
    assign hold_wanted = ~bus_hold_request_n_i;
    assign req_ready_o = idle & ~hold_wanted;

    // Access and hold sequencing
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        data_d = data_q;
        sel_d = sel_q;
        lanes_d = lanes_q;
        write_d = write_q;
        width_d = width_q;
        lo_d = lo_q;
        done_d = 1'b0;
        error_d = 1'b0;
        ack_d = ack_q;
        case (state_q)
            ST_IDLE: begin
                if (hold_wanted) begin
                    state_d = ST_RELEASE;
                end else if (req_valid_i) begin
                    if (dec_hit) begin
                        state_d = ST_ACCESS;
                        cnt_d = req_cycles;
                        addr_d = req_addr_i[24:0];
                        sel_d = dec_sel;
                        data_d = pack_data;
                        lanes_d = pack_lanes;
                        write_d = req_write_i;
                        width_d = req_width;
                        lo_d = req_addr_i[1:0];
                    end else begin
                        error_d = 1'b1;
                    end
                end
            end
            ST_ACCESS: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (cycle_extend_n_i) begin
                    state_d = ST_IDLE;
                    sel_d = {BANKS{1'b0}};
                    lanes_d = 4'h0;
                    write_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            ST_RELEASE: begin
                // Pins already released; acknowledge follows
                state_d = ST_HOLD;
                ack_d = 1'b1;
            end
            ST_HOLD: begin
                if (!hold_wanted) begin
                    state_d = ST_IDLE;
                    ack_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_IDLE;
                ack_d = 1'b0;
            end
        endcase
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            addr_q <= 25'h0000000;
            data_q <= 32'h00000000;
            sel_q <= {BANKS{1'b0}};
            lanes_q <= 4'h0;
            write_q <= 1'b0;
            width_q <= `EBI_WID_8;
            lo_q <= 2'h0;
            done_q <= 1'b0;
            error_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            data_q <= data_d;
            sel_q <= sel_d;
            lanes_q <= lanes_d;
            write_q <= write_d;
            width_q <= width_d;
            lo_q <= lo_d;
            done_q <= done_d;
            error_q <= error_d;
            ack_q <= ack_d;
        end
    end

    // Strap follows the pins through reset and freezes at release
    always @(posedge clock_i) begin
        if (srst_i) begin
            strap_q <= boot_width_select_i;
        end
    end

    // Read data caught on the completing cycle
    always @(posedge clock_i) begin
        if (srst_i) begin
            rdata_q <= 32'h00000000;
        end else if (state_q == ST_ACCESS && cnt_q == 4'h0 && cycle_extend_n_i && !write_q) begin
            rdata_q <= unpack_rdata;
        end
    end

    // Bank configuration registers
    always @(posedge clock_i) begin
        if (srst_i) begin
            for (i = 0; i < BANKS; i = i + 1) begin
                cfg_q[i] <= `EBI_CFG_RESET;
            end
        end else if (reg_we_i && reg_addr_i < `EBI_STATUS && reg_addr_i[1:0] == 2'h0) begin
            cfg_q[reg_addr_i[4:2]] <= reg_wdata_i[9:0];
        end
    end

    // Register read, answered one cycle later
    always @(posedge clock_i) begin
        if (srst_i) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_re_i) begin
            if (reg_addr_i < `EBI_STATUS && reg_addr_i[1:0] == 2'h0) begin
                reg_rdata_q <= {22'h000000, cfg_q[reg_addr_i[4:2]]};
            end else if (reg_addr_i == `EBI_STATUS) begin
                reg_rdata_q <= {27'h0000000, state_q[3] | state_q[2], state_q[1],
                    test_mode_o, boot_width};
            end else begin
                reg_rdata_q <= 32'h00000000;
            end
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata_o = reg_rdata_q;
    assign req_done_o = done_q;
    assign req_error_o = error_q;
    assign req_rdata_o = rdata_q;

    // Pin drive; everything released while the bus is lent
    assign ctrl_oe_n_o = state_q[2] | state_q[3];
    assign addr_o = addr_q;
    assign data_o = data_q;
    assign data_oe_n_o = ~(state_q[1] & write_q);
    assign bank_select_n_o = ~(sel_q & {BANKS{state_q[1]}});
    assign write_strobe_n_o = ~(state_q[1] & write_q);
    assign read_strobe_n_o = ~(state_q[1] & ~write_q);
    assign write_byte_lane_n_o = ~(lanes_q & {4{state_q[1] & write_q}});
    assign sram_byte_lane_n_o = ~(lanes_q & {4{state_q[1]}});
    assign bus_hold_ack_n_o = ~ack_q;
endmodule // external_bus_interface

// file: sim/ebi_chk.sv
// Purpose: Pin protocol checks for the bus controller
// Assumes: Bound to the top module
// Notes: One clock domain
`timescale 1ns/1ps
module ebi_chk #(
    parameter BANKS = 8
) (
    input wire clock_i,
    input wire srst_i,
    input wire req_ready_o,
    input wire req_done_o,
    input wire data_oe_n_o,
    input wire [BANKS-1:0] bank_select_n_o,
    input wire write_strobe_n_o,
    input wire read_strobe_n_o,
    input wire [3:0] write_byte_lane_n_o,
    input wire [3:0] sram_byte_lane_n_o,
    input wire ctrl_oe_n_o,
    input wire cycle_extend_n_i,
    input wire bus_hold_ack_n_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // Any strobe low
    wire act = !write_strobe_n_o || !read_strobe_n_o;
    // Pin relations
    a_one_select: assert property ($onehot0(~bank_select_n_o))
        else $error("two selects");
    a_held_idle: assert property (!bus_hold_ack_n_o |-> &bank_select_n_o && !act)
        else $error("active while lent");
    a_ack_release: assert property ($fell(bus_hold_ack_n_o) |-> $past(ctrl_oe_n_o))
        else $error("ack before release");
    a_lent_quiet: assert property (!bus_hold_ack_n_o |-> ctrl_oe_n_o && !req_ready_o)
        else $error("bus used while lent");
    a_write_drive: assert property (!write_strobe_n_o |-> read_strobe_n_o && !data_oe_n_o)
        else $error("write not driving");
    a_read_float: assert property (!read_strobe_n_o |-> data_oe_n_o && &write_byte_lane_n_o)
        else $error("read driving");
    a_lane_match: assert property (!write_strobe_n_o |-> write_byte_lane_n_o == sram_byte_lane_n_o)
        else $error("lanes differ");
    a_wait_hold: assert property (act && !cycle_extend_n_i |=> act && !req_done_o)
        else $error("ended in wait");
    // Main scenarios
    c_write: cover property (!write_strobe_n_o);
    c_wait: cover property (!read_strobe_n_o && !cycle_extend_n_i);
    c_lent: cover property ($fell(bus_hold_ack_n_o));
endmodule // ebi_chk

// file: sim/ext_mem.sv
// Purpose: Memory on the far side of the pins
// Assumes: One 16-word store for all banks
// Notes: Slow mode holds wait low three cycles
`timescale 1ns/1ps
module ext_mem (
    input wire clock_i,
    input wire slow_i,
    input wire [24:0] addr_i,
    input wire [31:0] wdata_i,
    input wire [7:0] sel_n_i,
    input wire we_n_i,
    input wire re_n_i,
    input wire [3:0] lanes_n_i,
    output wire [31:0] rdata_o,
    output wire wait_n_o
);
    reg [31:0] mem_q [0:15];
    reg [31:0] last_q = 32'h0;
    reg [3:0] cnt_q = 4'h0;
    integer k;
    wire act = !(&sel_n_i) && !(we_n_i && re_n_i);
    // Data only in a selected read, else junk
    assign rdata_o = act && !re_n_i ? mem_q[addr_i[5:2]] : ~last_q;
    assign wait_n_o = !(slow_i && act && cnt_q < 4'h3);
    // Store enabled bytes, count cycles
    always @(posedge clock_i) begin
        last_q <= rdata_o;
        cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            if (act && !we_n_i && !lanes_n_i[k]) begin
                mem_q[addr_i[5:2]][8*k +: 8] <= wdata_i[8*k +: 8];
            end
        end
    end
endmodule // ext_mem

// file: sim/testbench.sv
// Purpose: Directed bench for the bus controller
// Assumes: Memory model on pins, bench is other master
// Notes: Outputs sampled at falling edges
`timescale 1ns/1ps
module testbench;
    reg clock_i = 1'h0, srst_i = 1'h1, reg_we_i = 1'h0, reg_re_i = 1'h0, req_valid_i = 1'h0;
    reg req_write_i = 1'h0, slow = 1'h0, bus_hold_request_n_i = 1'h1, e;
    reg [1:0] boot_width_select_i = 2'h0;
    reg [7:0] reg_addr_i = 8'h00;
    reg [31:0] reg_wdata_i = 32'h0, req_wdata_i = 32'h0, got, seen;
    reg [7:0] ln;
    reg [27:0] req_addr_i = 28'h0;
    reg [3:0] req_be_i = 4'h0;
    wire [31:0] reg_rdata_o, req_rdata_o, data_i, data_o;
    wire [24:0] addr_o;
    wire [7:0] bank_select_n_o;
    wire [3:0] write_byte_lane_n_o, sram_byte_lane_n_o;
    wire req_ready_o, req_done_o, req_error_o, data_oe_n_o, write_strobe_n_o, read_strobe_n_o;
    wire ctrl_oe_n_o, cycle_extend_n_i, bus_hold_ack_n_o, test_mode_o;
    integer n_errors = 0, comparisons = 0, cyc, i, k;
    always #20 clock_i = ~clock_i;
    // Controller and memory
    external_bus_interface dut (.clock_i, .srst_i, .boot_width_select_i, .reg_addr_i, .reg_wdata_i,
        .reg_we_i, .reg_re_i, .reg_rdata_o, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
        .req_be_i, .req_ready_o, .req_done_o, .req_error_o, .req_rdata_o, .addr_o, .data_i, .data_o,
        .data_oe_n_o, .bank_select_n_o, .write_strobe_n_o, .read_strobe_n_o, .write_byte_lane_n_o,
        .sram_byte_lane_n_o, .ctrl_oe_n_o, .cycle_extend_n_i, .bus_hold_request_n_i,
        .bus_hold_ack_n_o, .test_mode_o);
    ext_mem mem (.clock_i, .slow_i(slow), .addr_i(addr_o), .wdata_i(data_o), .sel_n_i(bank_select_n_o),
        .we_n_i(write_strobe_n_o), .re_n_i(read_strobe_n_o), .lanes_n_i(write_byte_lane_n_o),
        .rdata_o(data_i), .wait_n_o(cycle_extend_n_i));
    task chk(input [31:0] g, input [31:0] x);
        begin
            comparisons = comparisons + 1;
            if (g !== x) begin
                n_errors = n_errors + 1;
                $display("BAD %0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task tmo;
        if (i >= 20) begin
            n_errors = n_errors + 1;
            finish_test;
        end
    endtask
    task boot(input [1:0] s);
        begin
            srst_i <= 1'h1;
            boot_width_select_i <= s;
            repeat (3) @(posedge clock_i);
            srst_i <= 1'h0;
            boot_width_select_i <= ~s;
        end
    endtask
    task wreg(input [7:0] a, input [31:0] d);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_we_i <= 1'h1;
            @(posedge clock_i);
            reg_we_i <= 1'h0;
        end
    endtask
    task rreg(input [7:0] a);
        begin
            reg_addr_i <= a;
            reg_re_i <= 1'h1;
            @(posedge clock_i);
            reg_re_i <= 1'h0;
            @(negedge clock_i);
            got = reg_rdata_o;
            @(posedge clock_i);
        end
    endtask
    // One access; counts cycles with a select low
    task acc(input w, input [27:0] a, input [31:0] d, input [3:0] b);
        begin
            req_valid_i <= 1'h1;
            req_write_i <= w;
            req_addr_i <= a;
            req_wdata_i <= d;
            req_be_i <= b;
            i = 0;
            @(negedge clock_i);
            while (req_ready_o !== 1'h1 && i < 20) begin
                i = i + 1;
                @(negedge clock_i);
            end
            tmo;
            @(posedge clock_i);
            req_valid_i <= 1'h0;
            cyc = 0;
            i = 0;
            @(negedge clock_i);
            while (req_done_o !== 1'h1 && req_error_o !== 1'h1 && i < 20) begin
                cyc = cyc + (bank_select_n_o !== 8'hFF);
                seen = {addr_o[23:0], bank_select_n_o};
                ln = {write_byte_lane_n_o, sram_byte_lane_n_o};
                i = i + 1;
                @(negedge clock_i);
            end
            tmo;
            e = req_error_o;
            @(posedge clock_i);
        end
    endtask
    // Directed sequence
    initial begin
        for (k = 0; k < 4; k = k + 1) begin
            boot(k[1:0]);
            rreg(8'h20);
            chk({28'h0, got[2], test_mode_o, got[1:0]}, {28'h0, {2{k == 3}}, (k == 3) ? 2'h2 : k[1:0]});
        end
        boot(2'h2);
        rreg(8'h04);
        chk(got, 32'h0000_000F);
        rreg(8'h40);
        chk(got, 32'h0);
        wreg(8'h04, 32'h0000_0200);
        acc(1'h1, 28'h200_0010, 32'h1234_5678, 4'hF);
        chk(cyc, 1);
        chk(seen, 32'h0000_10FD);
        acc(1'h1, 28'h200_0010, 32'h0000_AB00, 4'h2);
        acc(1'h0, 28'h200_0010, 32'h0, 4'hF);
        chk(req_rdata_o, 32'h1234_AB78);
        wreg(8'h04, 32'h0000_0203);
        acc(1'h0, 28'h200_0010, 32'h0, 4'hF);
        chk(cyc, 4);
        wreg(8'h04, 32'h0000_0200);
        slow <= 1'h1;
        acc(1'h0, 28'h200_0010, 32'h0, 4'hF);
        chk(cyc, 4);
        slow <= 1'h0;
        // Byte and halfword lanes on bank 1, then bank 0 at strap width
        wreg(8'h04, 32'h0000_0000);
        acc(1'h1, 28'h200_0011, 32'h0000_CD00, 4'h2);
        chk(ln, 8'hEE);
        acc(1'h0, 28'h200_0011, 32'h0, 4'hF);
        chk(ln, 8'hFE);
        chk(req_rdata_o, 32'h0000_CD00);
        wreg(8'h04, 32'h0000_0100);
        acc(1'h1, 28'h200_0012, 32'h5566_0000, 4'hC);
        chk(ln, 8'hCC);
        acc(1'h0, 28'h200_0012, 32'h0, 4'hF);
        chk(req_rdata_o, 32'h5566_0000);
        acc(1'h0, 28'h000_0010, 32'h0, 4'hF);
        chk(cyc, 16);
        chk(req_rdata_o, 32'h1234_5566);
        wreg(8'h04, 32'h0000_0270);
        acc(1'h0, 28'h210_0000, 32'h0, 4'hF);
        chk({e, cyc[30:0]}, 32'h8000_0000);
        bus_hold_request_n_i <= 1'h0;
        i = 0;
        @(negedge clock_i);
        while (bus_hold_ack_n_o !== 1'h0 && i < 20) begin
            i = i + 1;
            @(negedge clock_i);
        end
        tmo;
        chk({30'h0, ctrl_oe_n_o, req_ready_o}, 32'h2);
        @(posedge clock_i);
        bus_hold_request_n_i <= 1'h1;
        repeat (2) @(negedge clock_i);
        chk({30'h0, bus_hold_ack_n_o, req_ready_o}, 32'h3);
        finish_test;
    end
endmodule // testbench
bind external_bus_interface ebi_chk #(.BANKS(BANKS)) chk_u (.clock_i, .srst_i, .req_ready_o, .req_done_o,
    .data_oe_n_o, .bank_select_n_o, .write_strobe_n_o, .read_strobe_n_o, .write_byte_lane_n_o,
    .sram_byte_lane_n_o, .ctrl_oe_n_o, .cycle_extend_n_i, .bus_hold_ack_n_o);
